// ===== logic/mssc_ctrl.sv
// Module standby clock gating and sleep mode decoder with APB registers.
// Assumes the core pulses sleep_exec and wake_irq on pclk.
//
// Contract
// - Bit 7 low stops serial unit four
// - Bits 6,5 low stop serial channels
// - Bits 4,3 low stop converters
// - Bits 2,0 low stop timer F, rtc
// - Bit 1 low stops flash memory
// - Second register bits 7..5 stop units
// - Bits 4,1,0 stop pulse units, lcd
// - Bit 3 low stops event counter
// - Masked ROM: bits 7,1 reserved
// - Serial channel standby resets its registers
// - Watchdog standby ignored while watchdog runs
// - Watchdog stops when run flag clears
// - Sleep halts, interrupt resumes execution
// - External reset enters reset from any
// - Sleep enters high or medium sleep
// - Standby select picks standby or watch
// - Low speed watch resumes in subactive
// - Direct transition changes mode without halt
// - Medium flag resets 0, picks resume speed
`timescale 1ns/1ps
`default_nettype none
module mssc_ctrl #(
  parameter bit MASKED_ROM = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core and reset pin
  input wire logic external_reset_input,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic watchdog_run_flag,
  // Peripheral side
  output mssc_pkg::mssc_clk_en_type clk_en,
  output logic serial_chan_reset,
  output mssc_pkg::mssc_mode_type mode,
  output logic cpu_halted
);
  import mssc_pkg::*;

  logic [7:0] clk_stop_a_ff;
  logic [7:0] clk_stop_b_ff;
  mssc_flags_type flags_ff;
  logic [1:0] rst_sync_ff;
  logic [31:0] nxt_prdata;
  logic [7:0] a_mask;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  mssc_mode_type nxt_mode;
  mssc_flags_type f;
  logic halt_mode;

  assign halt_mode = (mode == MODE_SLEEP_HIGH) || (mode == MODE_SLEEP_MED) ||
    (mode == MODE_STANDBY) || (mode == MODE_WATCH);

  assign a_mask = MASKED_ROM ? MASKED_ROM_MASK : 8'hFF;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == CLK_STOP_A_OFFSET) || (paddr == CLK_STOP_B_OFFSET) ||
    (paddr == MODE_CTRL_OFFSET) || (paddr == MODE_STAT_OFFSET);

  // Reset pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], external_reset_input};
    end
  end

  // Clock-stop registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_stop_a_ff <= CLK_STOP_A_RESET;
      clk_stop_b_ff <= CLK_STOP_B_RESET;
    end else if (rst_sync_ff[1]) begin
      clk_stop_a_ff <= CLK_STOP_A_RESET;
      clk_stop_b_ff <= CLK_STOP_B_RESET;
    end else if (wr_en && paddr == CLK_STOP_A_OFFSET) begin
      clk_stop_a_ff <= (pwdata[7:0] & a_mask) | ~a_mask;
    end else if (wr_en && paddr == CLK_STOP_B_OFFSET) begin
      clk_stop_b_ff <= pwdata[7:0];
    end
  end

  // Mode flag register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= MODE_CTRL_RESET;
    end else if (rst_sync_ff[1]) begin
      flags_ff <= MODE_CTRL_RESET;
    end else if (wr_en && paddr == MODE_CTRL_OFFSET) begin
      flags_ff <= pwdata[4:0];
    end
  end

  // Read data
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      CLK_STOP_A_OFFSET: nxt_prdata = {24'h00_0000, clk_stop_a_ff & a_mask};
      CLK_STOP_B_OFFSET: nxt_prdata = {24'h00_0000, clk_stop_b_ff};
      MODE_CTRL_OFFSET: nxt_prdata = {27'h000_0000, flags_ff};
      MODE_STAT_OFFSET: nxt_prdata = {24'h00_0000, mode};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_en) begin
        prdata <= nxt_prdata;
      end
    end
  end

  // Sleep decoder, flags sampled at the instruction
  always_comb begin
    f = flags_ff;
    nxt_mode = mode;
    case (mode)
      MODE_RESET: begin
        nxt_mode = MODE_ACTIVE_HIGH;
      end
      MODE_ACTIVE_HIGH, MODE_ACTIVE_MED, MODE_SUBACTIVE: begin
        if (sleep_exec) begin
          if (f.direct_transition_flag) begin
            if (f.low_speed_flag && f.standby_select && f.watch_flag) begin
              nxt_mode = MODE_SUBACTIVE;
            end else begin
              nxt_mode = f.medium_speed_flag ? MODE_ACTIVE_MED : MODE_ACTIVE_HIGH;
            end
          end else if (!f.standby_select) begin
            nxt_mode = f.medium_speed_flag ? MODE_SLEEP_MED : MODE_SLEEP_HIGH;
          end else begin
            nxt_mode = (f.watch_flag || f.low_speed_flag) ? MODE_WATCH : MODE_STANDBY;
          end
        end
      end
      MODE_SLEEP_HIGH, MODE_SLEEP_MED, MODE_STANDBY, MODE_WATCH: begin
        if (wake_irq) begin
          if (mode == MODE_WATCH && f.low_speed_flag) begin
            nxt_mode = MODE_SUBACTIVE;
          end else begin
            nxt_mode = f.medium_speed_flag ? MODE_ACTIVE_MED : MODE_ACTIVE_HIGH;
          end
        end
      end
      default: nxt_mode = MODE_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= MODE_RESET;
      cpu_halted <= 1'b0;
    end else if (rst_sync_ff[1]) begin
      mode <= MODE_RESET;
      cpu_halted <= 1'b0;
    end else begin
      mode <= nxt_mode;
      cpu_halted <= (nxt_mode == MODE_SLEEP_HIGH) || (nxt_mode == MODE_SLEEP_MED) ||
        (nxt_mode == MODE_STANDBY) || (nxt_mode == MODE_WATCH);
    end
  end

  // Clock enables, one per standby bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_en
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          clk_en.group_a[gi] <= 1'b1;
          clk_en.group_b[gi] <= 1'b1;
        end else begin
          clk_en.group_a[gi] <= clk_stop_a_ff[gi] | ~a_mask[gi];
          if (gi == WATCHDOG_BIT) begin
            clk_en.group_b[gi] <= clk_stop_b_ff[gi] | watchdog_run_flag;
          end else begin
            clk_en.group_b[gi] <= clk_stop_b_ff[gi];
          end
        end
      end
    end
  endgenerate

  // Serial family register reset while either channel is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_chan_reset <= 1'b0;
    end else begin
      serial_chan_reset <= !clk_stop_a_ff[SERIAL_CHAN_A_BIT] || !clk_stop_a_ff[SERIAL_CHAN_B_BIT];
    end
  end

  // Assertions
  sequence s_sleep_std;
    sleep_exec && !rst_sync_ff[1] && (mode == MODE_ACTIVE_HIGH) && !flags_ff.direct_transition_flag &&
      !flags_ff.standby_select;
  endsequence

  a_gate_follows_bit: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 $fell(clk_stop_b_ff[LCD_BIT]) |=> !clk_en.group_b[LCD_BIT])
    else $error("lcd clock not gated");
  a_wdog_runs_on: assert property (@(posedge pclk) disable iff (!presetn)
    watchdog_run_flag |=> clk_en.group_b[WATCHDOG_BIT])
    else $error("watchdog stopped while running");
  a_wdog_stops: assert property (@(posedge pclk) disable iff (!presetn)
    (!clk_stop_b_ff[WATCHDOG_BIT] && !watchdog_run_flag) ##1 !clk_stop_b_ff[WATCHDOG_BIT]
    |-> !clk_en.group_b[WATCHDOG_BIT])
    else $error("watchdog not stopped");
  a_serial_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_stop_a_ff[SERIAL_CHAN_A_BIT] |=> serial_chan_reset)
    else $error("serial reset missing");
  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_std |=> (mode == MODE_SLEEP_HIGH || mode == MODE_SLEEP_MED) && cpu_halted)
    else $error("sleep not entered");
  a_wake_speed: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_STANDBY && wake_irq && !rst_sync_ff[1]) |=>
    mode == ($past(flags_ff.medium_speed_flag) ? MODE_ACTIVE_MED : MODE_ACTIVE_HIGH))
    else $error("wrong resume speed");
  a_reset_entry: assert property (@(posedge pclk) disable iff (!presetn)
    rst_sync_ff[1] |=> mode == MODE_RESET && !cpu_halted)
    else $error("reset not entered");
  a_masked_bits: assert property (@(posedge pclk) disable iff (!presetn)
    MASKED_ROM |-> clk_stop_a_ff[SERIAL_UNIT4_BIT] && clk_stop_a_ff[FLASH_BIT])
    else $error("reserved bit changed");
  a_direct_no_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_exec && flags_ff.direct_transition_flag && !rst_sync_ff[1] && mode == MODE_ACTIVE_HIGH)
    |=> !cpu_halted)
    else $error("direct transition halted");

  // Sleep instruction taken in a run mode
  sequence s_run_sleep;
    sleep_exec && !rst_sync_ff[1] && !halt_mode && (mode != MODE_RESET);
  endsequence

  // Interrupt while halted
  sequence s_halt_wake;
    halt_mode && wake_irq && !rst_sync_ff[1];
  endsequence

  // Halted with no interrupt
  sequence s_halt_idle;
    halt_mode && !wake_irq && !rst_sync_ff[1];
  endsequence

  // Per-bit gate checks
  for (genvar gc = 0; gc < 8; gc++) begin : g_chk
    a_gate_a_off: assert property (@(posedge pclk) disable iff (!presetn)
      (a_mask[gc] && !clk_stop_a_ff[gc]) |=> !clk_en.group_a[gc])
      else $error("first group clock not gated");
    a_gate_a_on: assert property (@(posedge pclk) disable iff (!presetn)
      clk_stop_a_ff[gc] |=> clk_en.group_a[gc])
      else $error("first group clock not restored");
    a_gate_b_off: assert property (@(posedge pclk) disable iff (!presetn)
      (gc != WATCHDOG_BIT) && !clk_stop_b_ff[gc] |=> !clk_en.group_b[gc])
      else $error("second group clock not gated");
    a_gate_b_on: assert property (@(posedge pclk) disable iff (!presetn)
      clk_stop_b_ff[gc] |=> clk_en.group_b[gc])
      else $error("second group clock not restored");
  end

  // Sleep entry targets
  a_sleep_med: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (!flags_ff.direct_transition_flag && !flags_ff.standby_select &&
    flags_ff.medium_speed_flag) |=> mode == MODE_SLEEP_MED)
    else $error("medium sleep not entered");
  a_sleep_high: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (!flags_ff.direct_transition_flag && !flags_ff.standby_select &&
    !flags_ff.medium_speed_flag) |=> mode == MODE_SLEEP_HIGH)
    else $error("high sleep not entered");
  a_standby_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (!flags_ff.direct_transition_flag && flags_ff.standby_select &&
    !flags_ff.watch_flag && !flags_ff.low_speed_flag) |=> mode == MODE_STANDBY)
    else $error("standby not entered");
  a_watch_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (!flags_ff.direct_transition_flag && flags_ff.standby_select &&
    flags_ff.watch_flag) |=> mode == MODE_WATCH && cpu_halted)
    else $error("watch not entered");
  a_low_watch: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (!flags_ff.direct_transition_flag && flags_ff.standby_select &&
    flags_ff.low_speed_flag) |=> mode == MODE_WATCH)
    else $error("unlisted low speed entry wrong");

  // Direct transitions
  a_direct_sub: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (flags_ff.direct_transition_flag && flags_ff.low_speed_flag &&
    flags_ff.standby_select && flags_ff.watch_flag) |=> mode == MODE_SUBACTIVE && !cpu_halted)
    else $error("direct subactive missing");
  a_direct_active: assert property (@(posedge pclk) disable iff (!presetn)
    s_run_sleep ##0 (flags_ff.direct_transition_flag && !(flags_ff.low_speed_flag &&
    flags_ff.standby_select && flags_ff.watch_flag)) |=>
    mode == ($past(flags_ff.medium_speed_flag) ? MODE_ACTIVE_MED : MODE_ACTIVE_HIGH))
    else $error("direct active speed wrong");

  // Wake and halt behaviour
  a_watch_sub_wake: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_wake ##0 (mode == MODE_WATCH && flags_ff.low_speed_flag) |=> mode == MODE_SUBACTIVE)
    else $error("watch wake not subactive");
  a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_wake ##0 !(mode == MODE_WATCH && flags_ff.low_speed_flag) |=>
    mode == ($past(flags_ff.medium_speed_flag) ? MODE_ACTIVE_MED : MODE_ACTIVE_HIGH))
    else $error("wake speed wrong");
  a_wake_runs: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_wake |=> !cpu_halted)
    else $error("still halted after wake");
  a_halt_holds: assert property (@(posedge pclk) disable iff (!presetn)
    s_halt_idle |=> $stable(mode) && cpu_halted)
    else $error("halt left without wake");
  a_halt_flag: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_halted == halt_mode)
    else $error("halt flag disagrees with mode");
  a_run_no_wake: assert property (@(posedge pclk) disable iff (!presetn)
    (!halt_mode && mode != MODE_RESET && !sleep_exec && !rst_sync_ff[1]) |=> $stable(mode))
    else $error("run mode changed without sleep");
  a_mode_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $onehot(mode))
    else $error("mode not one-hot");

  // Reset pin effects
  a_reset_regs: assert property (@(posedge pclk) disable iff (!presetn)
    rst_sync_ff[1] |=> clk_stop_a_ff == CLK_STOP_A_RESET && clk_stop_b_ff == CLK_STOP_B_RESET &&
    flags_ff == MODE_CTRL_RESET)
    else $error("registers not reset by pin");
  a_reset_exit: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_RESET && !rst_sync_ff[1]) |=> mode == MODE_ACTIVE_HIGH)
    else $error("reset not left to active");

  // Serial family reset and watchdog bit
  a_serial_b_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !clk_stop_a_ff[SERIAL_CHAN_B_BIT] |=> serial_chan_reset)
    else $error("serial b reset missing");
  a_serial_release: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_stop_a_ff[SERIAL_CHAN_A_BIT] && clk_stop_a_ff[SERIAL_CHAN_B_BIT]) |=> !serial_chan_reset)
    else $error("serial reset stuck");
  a_wdog_read: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == CLK_STOP_B_OFFSET && !rst_sync_ff[1]) |=> clk_stop_b_ff == $past(pwdata[7:0]))
    else $error("watchdog bit not stored");
  a_wdog_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (!watchdog_run_flag && clk_stop_b_ff[WATCHDOG_BIT]) |=> clk_en.group_b[WATCHDOG_BIT])
    else $error("watchdog clock not restored");
  a_masked_read: assert property (@(posedge pclk) disable iff (!presetn)
    (MASKED_ROM && rd_en && paddr == CLK_STOP_A_OFFSET) |=>
    prdata[SERIAL_UNIT4_BIT] == 1'b0 && prdata[FLASH_BIT] == 1'b0)
    else $error("reserved bit readable");

  // Bus answer
  a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready)
    else $error("ready missing in access");
  a_err_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

endmodule : mssc_ctrl
`default_nettype wire

// ===== include/mssc_pkg.sv
// Package for the module standby and sleep mode control block.
// Assumes an APB bus at 32-bit data and one system clock pclk.
package mssc_pkg;

  // Register byte offsets
  localparam logic [7:0] CLK_STOP_A_OFFSET = 8'h00;
  localparam logic [7:0] CLK_STOP_B_OFFSET = 8'h04;
  localparam logic [7:0] MODE_CTRL_OFFSET = 8'h08;
  localparam logic [7:0] MODE_STAT_OFFSET = 8'h0C;

  // Reset values
  localparam logic [7:0] CLK_STOP_A_RESET = 8'hFF;
  localparam logic [7:0] CLK_STOP_B_RESET = 8'hFF;

  // First clock-stop register bits
  localparam int SERIAL_UNIT4_BIT = 7;
  localparam int SERIAL_CHAN_A_BIT = 6;
  localparam int SERIAL_CHAN_B_BIT = 5;
  localparam int SAR_CONV_BIT = 4;
  localparam int SIGMA_CONV_BIT = 3;
  localparam int TIMER_F_BIT = 2;
  localparam int FLASH_BIT = 1;
  localparam int RTC_BIT = 0;

  // Second clock-stop register bits
  localparam int ADDR_BREAK_BIT = 7;
  localparam int MULTI_TIMER_BIT = 6;
  localparam int TWO_WIRE_BIT = 5;
  localparam int PULSE_UNIT2_BIT = 4;
  localparam int EVENT_COUNTER_BIT = 3;
  localparam int WATCHDOG_BIT = 2;
  localparam int PULSE_UNIT1_BIT = 1;
  localparam int LCD_BIT = 0;

  // Mode control register bits
  localparam int LOW_SPEED_BIT = 0;
  localparam int MEDIUM_SPEED_BIT = 1;
  localparam int STANDBY_SEL_BIT = 2;
  localparam int WATCH_BIT = 3;
  localparam int DIRECT_BIT = 4;
  localparam logic [4:0] MODE_CTRL_RESET = 5'h00;

  // Flash-less variant mask for reserved bits
  localparam logic [7:0] MASKED_ROM_MASK = 8'h7D;

  // Operating modes, one-hot
  typedef enum logic [7:0] {
    MODE_ACTIVE_HIGH = 8'h01,
    MODE_ACTIVE_MED = 8'h02,
    MODE_SLEEP_HIGH = 8'h04,
    MODE_SLEEP_MED = 8'h08,
    MODE_STANDBY = 8'h10,
    MODE_WATCH = 8'h20,
    MODE_SUBACTIVE = 8'h40,
    MODE_RESET = 8'h80
  } mssc_mode_type;

  // Mode flags carried together
  typedef struct packed {
    logic direct_transition_flag;
    logic watch_flag;
    logic standby_select;
    logic medium_speed_flag;
    logic low_speed_flag;
  } mssc_flags_type;

  // Per-peripheral clock enables
  typedef struct packed {
    logic [7:0] group_a;
    logic [7:0] group_b;
  } mssc_clk_en_type;

endpackage : mssc_pkg

// ===== verif/mssc_core_model.sv
// Core model: turns bench requests into sleep and wake pulses.
// Assumes one pclk domain shared with the control block.
`timescale 1ns/1ps
`default_nettype none
module mssc_core_model (
  // Clock
  input wire logic pclk,
  // Bench requests
  input wire logic sleep_req,
  input wire logic irq_req,
  // Block side
  input wire logic cpu_halted,
  output logic sleep_exec,
  output logic wake_irq
);
  // Sleep only while running, interrupt only while halted
  always_ff @(posedge pclk) begin
    sleep_exec <= sleep_req & ~cpu_halted;
    wake_irq <= irq_req & cpu_halted;
  end
endmodule : mssc_core_model
`default_nettype wire

// ===== verif/tb_top.sv
// Bench for the module standby and sleep mode control block.
// Assumes the core model and the block share pclk at 40 MHz.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mssc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, external_reset_input, watchdog_run_flag;
  logic sleep_req, irq_req, sleep_exec, wake_irq, pready, pslverr, serial_chan_reset, cpu_halted, e;
  logic [7:0] paddr, v, w;
  logic [31:0] pwdata, prdata, r;
  mssc_clk_en_type clk_en;
  mssc_mode_type mode;
  int n_fail, total_checks;
  logic [4:0] cases [11] = '{5'h00, 5'h02, 5'h04, 5'h06, 5'h0C, 5'h0E, 5'h0D, 5'h0F, 5'h10, 5'h12, 5'h1D};
  mssc_ctrl u_mssc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .external_reset_input, .sleep_exec, .wake_irq, .watchdog_run_flag,
    .clk_en, .serial_chan_reset, .mode, .cpu_halted);
  mssc_core_model u_mssc_core_model (.pclk, .sleep_req, .irq_req, .cpu_halted, .sleep_exec, .wake_irq);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tick;
    @(posedge pclk);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      n_fail++;
      wrap_up();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  task automatic wait_mode(input mssc_mode_type m);
    int n;
    n = 0;
    while (mode !== m && n < 20) begin
      tick;
      n++;
    end
    if (n >= 20) begin
      n_fail++;
      wrap_up();
    end
    chk({24'h0, mode}, {24'h0, m});
  endtask : wait_mode
  function automatic logic [15:0] exp_modes(input logic [4:0] f);
    mssc_mode_type act;
    act = f[1] ? MODE_ACTIVE_MED : MODE_ACTIVE_HIGH;
    if (f[4]) return (f[0] & f[2] & f[3]) ? {MODE_SUBACTIVE, MODE_SUBACTIVE} : {act, act};
    if (!f[2]) return {(f[1] ? MODE_SLEEP_MED : MODE_SLEEP_HIGH), act};
    if (f[0]) return {MODE_WATCH, MODE_SUBACTIVE};
    return {(f[3] ? MODE_WATCH : MODE_STANDBY), act};
  endfunction : exp_modes
  task automatic sleep_case(input logic [4:0] f);
    logic [15:0] x;
    x = exp_modes(f);
    apb(1'b1, MODE_CTRL_OFFSET, {27'h0, f});
    sleep_req <= 1'b1;
    tick;
    sleep_req <= 1'b0;
    tick;
    chk({24'h0, mode}, {24'h0, x[15:8]});
    chk({31'h0, cpu_halted}, {31'h0, ~f[4]});
    if (!f[4]) begin
      irq_req <= 1'b1;
      repeat (2) tick;
      irq_req <= 1'b0;
      tick;
      chk({24'h0, mode}, {24'h0, x[7:0]});
    end
    if (x[7:0] == MODE_SUBACTIVE) sleep_case(5'h10);
  endtask : sleep_case
  initial begin
    {presetn, psel, penable, pwrite, external_reset_input, watchdog_run_flag, sleep_req, irq_req} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(8874));
    repeat (6) @(posedge pclk);
    chk({24'h0, mode}, 32'h80);
    presetn <= 1'b1;
    tick;
    chk({24'h0, mode}, 32'h01);
    chk({16'h0, clk_en}, 32'hFFFF);
    rd(CLK_STOP_A_OFFSET, 32'hFF);
    rd(CLK_STOP_B_OFFSET, 32'hFF);
    rd(MODE_CTRL_OFFSET, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : 8'($urandom);
      apb(1'b1, CLK_STOP_A_OFFSET, {24'h0, v});
      tick;
      chk({24'h0, clk_en.group_a}, {24'h0, v});
      chk({31'h0, serial_chan_reset}, {31'h0, ~(v[6] & v[5])});
      rd(CLK_STOP_A_OFFSET, {24'h0, v});
      w = (i == 0) ? 8'h00 : 8'($urandom);
      apb(1'b1, CLK_STOP_B_OFFSET, {24'h0, w});
      tick;
      chk({24'h0, clk_en.group_b}, {24'h0, w});
    end
    apb(1'b1, CLK_STOP_A_OFFSET, 32'hFF);
    rd(CLK_STOP_A_OFFSET, 32'hFF);
    $display("clock stop test done");
    apb(1'b1, CLK_STOP_B_OFFSET, 32'hFF);
    watchdog_run_flag <= 1'b1;
    apb(1'b1, CLK_STOP_B_OFFSET, 32'hFB);
    rd(CLK_STOP_B_OFFSET, 32'hFB);
    tick;
    chk({31'h0, clk_en.group_b[WATCHDOG_BIT]}, 32'h1);
    watchdog_run_flag <= 1'b0;
    repeat (2) tick;
    chk({31'h0, clk_en.group_b[WATCHDOG_BIT]}, 32'h0);
    $display("watchdog test done");
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h1);
    rd(8'h10, 32'h0);
    $display("unmapped test done");
    foreach (cases[k]) sleep_case(cases[k]);
    $display("sleep test done");
    apb(1'b1, CLK_STOP_A_OFFSET, 32'h0);
    apb(1'b1, MODE_CTRL_OFFSET, 32'h02);
    external_reset_input <= 1'b1;
    wait_mode(MODE_RESET);
    external_reset_input <= 1'b0;
    wait_mode(MODE_ACTIVE_HIGH);
    rd(CLK_STOP_A_OFFSET, 32'hFF);
    rd(MODE_CTRL_OFFSET, 32'h0);
    $display("external reset test done");
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
